// ### hw/uptc_defines.vh
// Offsets, field positions and reset values of the PHY test register bank
`ifndef UPTC_DEFINES_VH
`define UPTC_DEFINES_VH
`define UPTC_OFF_SHARED     12'h000
`define UPTC_OFF_FRONTEND   12'h0c4
`define UPTC_OFF_CFG        12'h0d0
`define UPTC_SH_CLK_OK      12
`define UPTC_SH_TXPLL_ON    11
`define UPTC_SH_TXPLL_OK    10
`define UPTC_SH_RDYTIM_OFF  9
`define UPTC_SH_FASTSTART   17
`define UPTC_SH_GATE_BYP    0
`define UPTC_FE_DRV_OFF_N   22
`define UPTC_FE_PLUS        21
`define UPTC_FE_MINUS       20
`define UPTC_FE_RX_LEVEL    19
`define UPTC_FE_MASK_HI     15
`define UPTC_FE_MASK_LO     14
`define UPTC_FE_BITS_HI     13
`define UPTC_FE_BITS_LO     12
`define UPTC_FE_CS_ON       11
`define UPTC_FE_TRIM_HI     10
`define UPTC_FE_TRIM_LO     8
`define UPTC_FE_PULLUP      7
`define UPTC_CFG_PROTECT    0
`define UPTC_TRIM_RST       3'h0
`define UPTC_MASK_BAD       2'h2
`endif

// ### hw/uptc_regs.v
// AHB-Lite register bank for the USB PHY test and front-end control bits
// Notes on behaviour
// - Bit 12 reads whether the common PLL clocks are usable.
// - Bit 11 turns the transmit PLL on, cleared at reset.
// - Bit 10 reads whether the transmit PLL clocks are usable.
// - Bit 9 set disables the front-end ready timer.
// - Bit 0 set forces all clock gating into bypass.
// - Fast-start default from EEPROM flags, else OTP, else zero.
// - Flag choice for fast-start depends on high-speed or full-speed mode.
// - USB or lite reset reloads fast-start from last loaded image.
// - Bit 22 is active-low full-speed driver disable.
// - Bits 21 and 20 drive plus and minus data outputs.
// - Bit 19 reads the full-speed differential receiver.
// - Bits 15:14 mask valid transmit lanes; code 10 is invalid.
// - High-speed transmit bits 13:12 are sent low bit first.
// - Bit 11 powers the current source; forced on in high-speed mode.
// - Bits 10:8 trim drive current; 000 nominal, 001 minus five percent.
// - Reset protection keeps the trim field across USB and lite resets; hardware reset still clears it.
// - Bit 7 enables the D+ pull-up, off at reset.
// - Shared block test register sits at offset zero.
`timescale 1ns/100ps
`include "uptc_defines.vh"

module uptc_regs (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        usb_reset,
  input  wire        lite_soft_reset,
  input  wire        hs_mode,
  input  wire        eeprom_present,
  input  wire        otp_present,
  input  wire        eeprom_fast_start_hs,
  input  wire        eeprom_fast_start_fs,
  input  wire        otp_fast_start_hs,
  input  wire        otp_fast_start_fs,
  input  wire [2:0]  eeprom_trim,
  input  wire [2:0]  otp_trim,
  input  wire        common_pll_clock_ok,
  input  wire        ss_tx_pll_ok,
  input  wire        fullspeed_rx_level,
  output reg         ss_tx_pll_on,
  output reg         frontend_ready_timer_off,
  output reg         gating_bypass_force,
  output reg         hs_pll_fast_start,
  output reg         fullspeed_drive_off_n,
  output reg         fullspeed_plus_out,
  output reg         fullspeed_minus_out,
  output reg  [1:0]  frontend_hs_tx_lane_valid,
  output reg         hs_tx_serial,
  output reg         hs_current_source_on,
  output reg  [2:0]  hs_drive_current_trim,
  output reg         dp_pullup_on
);

  // Status and strap inputs come from other domains
  reg  [3:0]  sync1_ff;
  reg  [3:0]  sync2_ff;
  // Strap levels are pins too, so they pass two flops as well
  reg  [12:0] strap1_ff;
  reg  [12:0] strap2_ff;
  reg         wr_pend_ff;
  reg  [11:0] wr_addr_ff;
  reg         rst_protect_ff;
  reg  [1:0]  hs_tx_lane_mask_ff;
  reg  [1:0]  hs_tx_bits_ff;
  reg         cs_bit_ff;
  reg         bit_idx_ff;
  reg         soft_rst_d_ff;
  wire        soft_rst;
  wire        soft_rst_edge;
  wire        addr_ok;
  wire        fast_start_img;
  wire [2:0]  trim_img;
  reg  [31:0] nxt_rdata;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign soft_rst  = usb_reset | lite_soft_reset;
  assign soft_rst_edge = soft_rst & ~soft_rst_d_ff;

  assign fast_start_img = strap2_ff[12] ?
                          (sync2_ff[3] ? strap2_ff[10] : strap2_ff[9]) :
                          strap2_ff[11] ?
                          (sync2_ff[3] ? strap2_ff[8] : strap2_ff[7]) : 1'b0;
  assign trim_img = strap2_ff[12] ? strap2_ff[5:3] :
                    strap2_ff[11] ? strap2_ff[2:0] : `UPTC_TRIM_RST;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff  <= 4'h0;
      sync2_ff  <= 4'h0;
      strap1_ff <= 13'h0000;
      strap2_ff <= 13'h0000;
    end else begin
      sync1_ff  <= {hs_mode, fullspeed_rx_level, ss_tx_pll_ok, common_pll_clock_ok};
      sync2_ff  <= sync1_ff;
      strap1_ff <= {eeprom_present, otp_present, eeprom_fast_start_hs, eeprom_fast_start_fs,
                    otp_fast_start_hs, otp_fast_start_fs, 1'b0, eeprom_trim, otp_trim};
      strap2_ff <= strap1_ff;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata     <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_ok & hwrite;
      wr_addr_ff <= haddr;
      hrdata     <= (addr_ok & ~hwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // reserved bits and unmapped words read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case ({haddr[11:2], 2'b00})
      `UPTC_OFF_SHARED: begin
        nxt_rdata[`UPTC_SH_FASTSTART]  = hs_pll_fast_start;
        nxt_rdata[`UPTC_SH_CLK_OK]     = sync2_ff[0];
        nxt_rdata[`UPTC_SH_TXPLL_ON]   = ss_tx_pll_on;
        nxt_rdata[`UPTC_SH_TXPLL_OK]   = sync2_ff[1];
        nxt_rdata[`UPTC_SH_RDYTIM_OFF] = frontend_ready_timer_off;
        nxt_rdata[`UPTC_SH_GATE_BYP]   = gating_bypass_force;
      end
      `UPTC_OFF_FRONTEND: begin
        nxt_rdata[`UPTC_FE_DRV_OFF_N] = fullspeed_drive_off_n;
        nxt_rdata[`UPTC_FE_PLUS]      = fullspeed_plus_out;
        nxt_rdata[`UPTC_FE_MINUS]     = fullspeed_minus_out;
        nxt_rdata[`UPTC_FE_RX_LEVEL]  = sync2_ff[2];
        nxt_rdata[`UPTC_FE_MASK_HI:`UPTC_FE_MASK_LO] = hs_tx_lane_mask_ff;
        nxt_rdata[`UPTC_FE_BITS_HI:`UPTC_FE_BITS_LO] = hs_tx_bits_ff;
        nxt_rdata[`UPTC_FE_CS_ON]     = cs_bit_ff;
        nxt_rdata[`UPTC_FE_TRIM_HI:`UPTC_FE_TRIM_LO] = hs_drive_current_trim;
        nxt_rdata[`UPTC_FE_PULLUP]    = dp_pullup_on;
      end
      `UPTC_OFF_CFG: begin
        nxt_rdata[`UPTC_CFG_PROTECT] = rst_protect_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Register writes land in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_tx_pll_on             <= 1'b0;
      frontend_ready_timer_off <= 1'b0;
      gating_bypass_force      <= 1'b0;
      hs_pll_fast_start        <= 1'b0;
      fullspeed_drive_off_n    <= 1'b0;
      fullspeed_plus_out       <= 1'b0;
      fullspeed_minus_out      <= 1'b0;
      hs_tx_lane_mask_ff       <= 2'h0;
      hs_tx_bits_ff            <= 2'h0;
      cs_bit_ff                <= 1'b0;
      hs_drive_current_trim    <= `UPTC_TRIM_RST;
      dp_pullup_on             <= 1'b0;
      rst_protect_ff           <= 1'b0;
      soft_rst_d_ff            <= 1'b0;
    end else begin
      soft_rst_d_ff <= soft_rst;
      if (soft_rst) begin
        hs_pll_fast_start <= fast_start_img;
        if (!rst_protect_ff)
          hs_drive_current_trim <= trim_img;
        dp_pullup_on <= 1'b0;
      end else if (wr_pend_ff) begin
        case ({wr_addr_ff[11:2], 2'b00})
          `UPTC_OFF_SHARED: begin
            hs_pll_fast_start        <= hwdata[`UPTC_SH_FASTSTART];
            ss_tx_pll_on             <= hwdata[`UPTC_SH_TXPLL_ON];
            frontend_ready_timer_off <= hwdata[`UPTC_SH_RDYTIM_OFF];
            gating_bypass_force      <= hwdata[`UPTC_SH_GATE_BYP];
          end
          `UPTC_OFF_FRONTEND: begin
            fullspeed_drive_off_n <= hwdata[`UPTC_FE_DRV_OFF_N];
            fullspeed_plus_out    <= hwdata[`UPTC_FE_PLUS];
            fullspeed_minus_out   <= hwdata[`UPTC_FE_MINUS];
            hs_tx_lane_mask_ff    <= hwdata[`UPTC_FE_MASK_HI:`UPTC_FE_MASK_LO];
            hs_tx_bits_ff         <= hwdata[`UPTC_FE_BITS_HI:`UPTC_FE_BITS_LO];
            cs_bit_ff             <= hwdata[`UPTC_FE_CS_ON];
            // trim code passed to the driver
            hs_drive_current_trim <= hwdata[`UPTC_FE_TRIM_HI:`UPTC_FE_TRIM_LO];
            dp_pullup_on          <= hwdata[`UPTC_FE_PULLUP];
          end
          `UPTC_OFF_CFG: begin
            rst_protect_ff <= hwdata[`UPTC_CFG_PROTECT];
          end
          default: begin
            rst_protect_ff <= rst_protect_ff;
          end
        endcase
      end else if (soft_rst_edge) begin
        rst_protect_ff <= rst_protect_ff;
      end
    end
  end

  // lane mask decode, invalid code yields no lanes
  // low bit first on serial output
  // current source forced in high-speed mode
  // plus and minus already drive pins from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frontend_hs_tx_lane_valid <= 2'h0;
      hs_tx_serial              <= 1'b0;
      bit_idx_ff                <= 1'b0;
      hs_current_source_on      <= 1'b0;
    end else begin
      frontend_hs_tx_lane_valid <= (hs_tx_lane_mask_ff == `UPTC_MASK_BAD) ? 2'h0 :
                                   hs_tx_lane_mask_ff;
      bit_idx_ff   <= hs_tx_lane_mask_ff[1] ? ~bit_idx_ff : 1'b0;
      hs_tx_serial <= hs_tx_lane_mask_ff[0] & hs_tx_bits_ff[bit_idx_ff];
      hs_current_source_on <= cs_bit_ff | sync2_ff[3];
    end
  end

endmodule // uptc_regs

// ### tb/uptc_regs_properties.sv
// Concurrent checks on the PHY test register bank ports
`timescale 1ns/100ps
module uptc_regs_properties (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        usb_reset,
  input wire        lite_soft_reset,
  input wire        hs_mode,
  input wire        ss_tx_pll_on,
  input wire        frontend_ready_timer_off,
  input wire        gating_bypass_force,
  input wire        fullspeed_drive_off_n,
  input wire        fullspeed_plus_out,
  input wire        fullspeed_minus_out,
  input wire [1:0]  frontend_hs_tx_lane_valid,
  input wire        hs_current_source_on,
  input wire [2:0]  hs_drive_current_trim,
  input wire        dp_pullup_on
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans[1];
  wire sr = usb_reset || lite_soft_reset;
  wire rd = tk && !hwrite;
  chk_no_wait: assert property (hreadyout && !hresp) else $error("bus stalled or erred");
  chk_lane_legal: assert property (frontend_hs_tx_lane_valid != 2'h2)
    else $error("invalid lane mask passed");
  chk_cs_in_hs: assert property (hs_mode [*5] |-> hs_current_source_on)
    else $error("current source off in high speed");
  chk_soft_pullup: assert property (sr |=> !dp_pullup_on) else $error("pull-up kept");
  chk_reset_zero: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !ss_tx_pll_on)
    else $error("outputs not cleared by reset");
  chk_wr_shared: assert property (tk && hwrite && haddr == 12'h000 && !sr ##1 !sr ##1 !sr
    |=> {ss_tx_pll_on, frontend_ready_timer_off, gating_bypass_force} ==
    {$past(hwdata[11], 2), $past(hwdata[9], 2), $past(hwdata[0], 2)}) else $error("shared write lost");
  chk_wr_front: assert property (tk && hwrite && haddr == 12'h0c4 && !sr ##1 !sr ##1 !sr
    |=> {fullspeed_drive_off_n, fullspeed_plus_out, fullspeed_minus_out, hs_drive_current_trim,
    dp_pullup_on} == {$past(hwdata[22], 2), $past(hwdata[21], 2), $past(hwdata[20], 2),
    $past(hwdata[10:8], 2), $past(hwdata[7], 2)}) else $error("front-end write lost");
  chk_rd_shared: assert property (rd && haddr == 12'h000 |=> (hrdata & 32'hfffd_e1fe) == 0)
    else $error("shared reserved bits set");
  chk_rd_front: assert property (rd && haddr == 12'h0c4 |=> (hrdata & 32'hff87_007f) == 0)
    else $error("front-end reserved bits set");
  chk_rd_unmapped: assert property (rd && haddr == 12'h008 |=> hrdata == 0)
    else $error("unmapped read not zero");
endmodule // uptc_regs_properties
bind uptc_regs uptc_regs_properties i_chk (.*);

// ### tb/uptc_tb.sv
// Self-checking bench for the PHY test register bank
`timescale 1ns/100ps
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, usb_reset = 0, lite_soft_reset = 0;
  logic hs_mode = 0, eeprom_present = 0, otp_present = 0, eeprom_fast_start_hs = 0;
  logic eeprom_fast_start_fs = 0, otp_fast_start_hs = 0, otp_fast_start_fs = 0, rd_pend = 0;
  logic common_pll_clock_ok = 1, ss_tx_pll_ok = 0, fullspeed_rx_level = 1, f, p;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, eeprom_trim = 0, otp_trim = 0, t;
  logic [31:0] hwdata = 0, sh_m = 0, fe_m = 0, d, q[$];
  wire hreadyout, hresp, ss_tx_pll_on, frontend_ready_timer_off, gating_bypass_force;
  wire hs_pll_fast_start, fullspeed_drive_off_n, fullspeed_plus_out, fullspeed_minus_out;
  wire hs_tx_serial, hs_current_source_on, dp_pullup_on, hready = hreadyout;
  wire [1:0] frontend_hs_tx_lane_valid;
  wire [2:0] hs_drive_current_trim;
  wire [31:0] hrdata;
  int fails = 0, checked = 0;
  uptc_regs i_dut (.*);
  always #2 hclk = ~hclk;
  task automatic conclude;
    $display("counts checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // Bounded wait for hready at the next edges
  task automatic step;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fails++;
      conclude;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dt);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    step;
    {hsel, htrans} <= 3'h0;
    hwdata <= w ? dt : $urandom;
    step;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dt);
    xfer(1, a, dt);
    // Idle edge, though a read straight after a write already sees the new value
    @(posedge hclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(0, a, 32'h0);
  endtask
  function automatic logic [31:0] exp_sh;
    return sh_m | {19'h0, common_pll_clock_ok, 1'b0, ss_tx_pll_ok, 10'h0};
  endfunction
  function automatic logic [31:0] exp_fe;
    return fe_m | {12'h0, fullspeed_rx_level, 19'h0};
  endfunction
  always @(posedge hclk) begin
    if (rd_pend)
      chk("hrdata", q.pop_front(), hrdata);
    rd_pend <= hsel && hready && htrans[1] && !hwrite;
  end
  initial begin
    void'($urandom(32'h3bcb));
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    repeat (4) @(posedge hclk);
    rd(12'h000, exp_sh());
    rd(12'h0c4, exp_fe());
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      {common_pll_clock_ok, ss_tx_pll_ok, fullspeed_rx_level} <= 3'($urandom);
      d = $urandom;
      wr(12'h000, d);
      sh_m = d & 32'h0002_0a01;
      d = $urandom;
      d[15:14] = i[1:0];
      wr(12'h0c4, d);
      fe_m = d & 32'h0070_ff80;
      repeat (3) @(posedge hclk);
      rd(12'h000, exp_sh());
      rd(12'h0c4, exp_fe());
      chk("lane", (i[1:0] == 2'h2) ? 32'h0 : 32'(i[1:0]), 32'(frontend_hs_tx_lane_valid));
      if (i[1:0] != 2'h3)
        chk("serial", 32'(i[1:0] == 2'h1 && d[12]), 32'(hs_tx_serial));
    end
    $display("test write readback done");
    for (int i = 0; i < 6; i++) begin
      p = i >= 3;
      wr(12'h0d0, 32'(p));
      {eeprom_present, otp_present, hs_mode, eeprom_fast_start_hs, eeprom_fast_start_fs,
        otp_fast_start_hs, otp_fast_start_fs, eeprom_trim, otp_trim} <= 13'($urandom);
      repeat (5) @(posedge hclk);
      f = eeprom_present ? (hs_mode ? eeprom_fast_start_hs : eeprom_fast_start_fs) :
        otp_present ? (hs_mode ? otp_fast_start_hs : otp_fast_start_fs) : 1'b0;
      t = p ? fe_m[10:8] : eeprom_present ? eeprom_trim : otp_present ? otp_trim : 3'h0;
      if (i[0]) usb_reset <= 1;
      else lite_soft_reset <= 1;
      @(posedge hclk);
      {usb_reset, lite_soft_reset} <= 2'h0;
      @(posedge hclk);
      sh_m[17] = f;
      fe_m[10:8] = t;
      fe_m[7] = 1'b0;
      chk("fast_start", 32'(f), 32'(hs_pll_fast_start));
      rd(12'h000, exp_sh());
      rd(12'h0c4, exp_fe());
    end
    $display("test soft reset reload done");
    // reserved words are only read, never written
    rd(12'h008, 32'h0);
    rd(12'h13c, 32'h0);
    $display("test unmapped reads done");
    @(posedge hclk);
    conclude;
  end
endmodule // tb
